// ==== design/aeb_pkg.sv ====
package aeb_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_START   = 12'h000;
    localparam logic [11:0] OFF_STOP    = 12'h004;
    localparam logic [11:0] OFF_DONE    = 12'h100;
    localparam logic [11:0] OFF_ERROR   = 12'h104;
    localparam logic [11:0] OFF_IEN_SET = 12'h304;
    localparam logic [11:0] OFF_IEN_CLR = 12'h308;
    localparam logic [11:0] OFF_PTR     = 12'h504;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          BIT_TRIGGER = 0;
    localparam int          BIT_EVENT   = 0;
    localparam int          IEN_DONE    = 0;
    localparam int          IEN_ERROR   = 1;
    localparam logic [31:0] PTR_RST     = 32'h0000_0000;
    localparam logic [1:0]  IEN_RST     = 2'h0;

    // ------------------------------------------------------------
    // block structure layout, byte offsets
    // ------------------------------------------------------------
    localparam logic [31:0] STRUCT_KEY   = 32'h0000_0000;
    localparam logic [31:0] STRUCT_CLEAR = 32'h0000_0010;
    localparam logic [31:0] STRUCT_CIPH  = 32'h0000_0020;
    localparam logic [32:0] STRUCT_LEN   = 33'h0_0000_0030;
    localparam logic [3:0]  LAST_RD_WORD = 4'h7;
    localparam logic [3:0]  LAST_WR_WORD = 4'h3;

    // ------------------------------------------------------------
    // data ram window the dma may reach
    // ------------------------------------------------------------
    localparam logic [32:0] RAM_BASE = 33'h0_2000_0000;
    localparam logic [32:0] RAM_SIZE = 33'h0_0000_8000;

    // ------------------------------------------------------------
    // control states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_CORE,
        ST_STORE
    } aeb_state_t;

endpackage : aeb_pkg

// ==== design/aeb_block_encrypt.sv ====
`timescale 1ns/1ps
// What this block does
// - encrypt only, 128-bit ECB, no decrypt
// - start fetches key, cleartext, then computes
// - done event only after ciphertext written
// - stop task aborts running encryption
// - higher-priority core claim aborts, raises error
// - dma stays in data ram window unless ptr is rewritten before core done
// - dma idle before done or error
// - key 0, cleartext 16, ciphertext 32
// - all accesses relative to one pointer
// - start with core busy raises error
// - stop abort raises error event
// - start 0x000, stop 0x004, write one
// - event flags read state, write loads bit 0
// - enable set register at 0x304
// - enable clear register at 0x308
// - pointer at 0x504, reset zero
module aeb_block_encrypt (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         arst_n,
    // register port
    input  wire logic [11:0]  regAddr,
    input  wire logic [31:0]  regWdata,
    input  wire logic         regWr,
    input  wire logic         regRd,
    output logic      [31:0]  regRdata,
    // dma master to data ram
    output logic              memReq,
    output logic              memWe,
    output logic      [31:0]  memAddr,
    output logic      [31:0]  memWdata,
    input  wire logic         memAck,
    input  wire logic [31:0]  memRdata,
    // shared aes core
    input  wire logic         coreBusy,
    input  wire logic         coreClaim,
    output logic              coreStart,
    output logic      [127:0] coreKey,
    output logic      [127:0] coreText,
    input  wire logic         coreDone,
    input  wire logic [127:0] coreResult,
    // interrupt
    output logic              irq
);

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        aeb_pkg::aeb_state_t st;
        logic [31:0]         ptr;
        logic                evtDone;
        logic                evtErr;
        logic [1:0]          ien;
        logic [3:0]          idx;
        logic                abortPend;
        logic [127:0]        key;
        logic [127:0]        text;
        logic [127:0]        ciph;
        logic                memReq;
        logic                memWe;
        logic [31:0]         memAddr;
        logic [31:0]         memWdata;
        logic                coreStart;
        logic [31:0]         rdata;
        logic                irq;
    } aeb_regs_t;

    aeb_regs_t s_r;
    aeb_regs_t s_nxt;

    // ------------------------------------------------------------
    // decoded strobes
    // ------------------------------------------------------------
    logic        wrStart;
    logic        wrStop;
    logic        wrDone;
    logic        wrErr;
    logic        wrIenSet;
    logic        wrIenClr;
    logic        wrPtr;
    logic        startTask;
    logic        stopTask;
    logic        ptrInRam;
    logic [32:0] ptrEnd;

    assign wrStart  = regWr && (regAddr == aeb_pkg::OFF_START);
    assign wrStop   = regWr && (regAddr == aeb_pkg::OFF_STOP);
    assign wrDone   = regWr && (regAddr == aeb_pkg::OFF_DONE);
    assign wrErr    = regWr && (regAddr == aeb_pkg::OFF_ERROR);
    assign wrIenSet = regWr && (regAddr == aeb_pkg::OFF_IEN_SET);
    assign wrIenClr = regWr && (regAddr == aeb_pkg::OFF_IEN_CLR);
    assign wrPtr    = regWr && (regAddr == aeb_pkg::OFF_PTR);

    assign startTask = wrStart && regWdata[aeb_pkg::BIT_TRIGGER];
    assign stopTask  = wrStop && regWdata[aeb_pkg::BIT_TRIGGER];

    // whole structure must sit inside the ram window
    assign ptrEnd   = {1'b0, s_r.ptr} + aeb_pkg::STRUCT_LEN;
    assign ptrInRam = ({1'b0, s_r.ptr} >= aeb_pkg::RAM_BASE)
                   && (ptrEnd <= aeb_pkg::RAM_BASE + aeb_pkg::RAM_SIZE);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic        setDone;
        logic        setErr;
        logic        accDone;
        logic        kill;
        logic [6:0]  lane;
        setDone = 1'b0;
        setErr  = 1'b0;
        accDone = 1'b0;
        kill    = 1'b0;
        lane    = {s_r.idx[1:0], 5'h00};
        s_nxt   = s_r;
        s_nxt.coreStart = 1'b0;

        // access finishes on ack of the held request
        accDone = s_r.memReq && memAck;
        // abort sources while running
        kill = (s_r.st != aeb_pkg::ST_IDLE) && (stopTask || coreClaim);

        unique case (s_r.st)
            aeb_pkg::ST_IDLE: begin
                if (startTask) begin
                    if (coreBusy || !ptrInRam) begin
                        setErr = 1'b1;
                    end else begin
                        // key words 0..3, then cleartext 4..7
                        s_nxt.st      = aeb_pkg::ST_FETCH;
                        s_nxt.idx     = 4'h0;
                        s_nxt.memReq  = 1'b1;
                        s_nxt.memWe   = 1'b0;
                        s_nxt.memAddr = s_r.ptr + aeb_pkg::STRUCT_KEY;
                        s_nxt.abortPend = 1'b0;
                    end
                end
            end
            aeb_pkg::ST_FETCH: begin
                if (accDone) begin
                    if (s_r.idx[2]) begin
                        s_nxt.text[lane +: 32] = memRdata;
                    end else begin
                        s_nxt.key[lane +: 32] = memRdata;
                    end
                end
                if (kill || s_r.abortPend) begin
                    // let the open access finish before reporting
                    if (accDone) begin
                        s_nxt.memReq = 1'b0;
                        s_nxt.st     = aeb_pkg::ST_IDLE;
                        setErr       = 1'b1;
                    end else begin
                        s_nxt.abortPend = 1'b1;
                    end
                end else if (accDone) begin
                    if (s_r.idx == aeb_pkg::LAST_RD_WORD) begin
                        s_nxt.memReq    = 1'b0;
                        s_nxt.st        = aeb_pkg::ST_CORE;
                        s_nxt.coreStart = 1'b1;
                    end else begin
                        s_nxt.idx     = s_r.idx + 4'h1;
                        s_nxt.memAddr = s_r.memAddr + 32'h0000_0004;
                    end
                end
            end
            aeb_pkg::ST_CORE: begin
                if (kill) begin
                    s_nxt.st = aeb_pkg::ST_IDLE;
                    setErr   = 1'b1;
                end else if (coreDone) begin
                    s_nxt.ciph     = coreResult;
                    s_nxt.st       = aeb_pkg::ST_STORE;
                    s_nxt.idx      = 4'h0;
                    s_nxt.memReq   = 1'b1;
                    s_nxt.memWe    = 1'b1;
                    s_nxt.memAddr  = s_r.ptr + aeb_pkg::STRUCT_CIPH;
                    s_nxt.memWdata = coreResult[31:0];
                end
            end
            aeb_pkg::ST_STORE: begin
                if (kill || s_r.abortPend) begin
                    if (accDone) begin
                        s_nxt.memReq = 1'b0;
                        s_nxt.memWe  = 1'b0;
                        s_nxt.st     = aeb_pkg::ST_IDLE;
                        setErr       = 1'b1;
                    end else begin
                        s_nxt.abortPend = 1'b1;
                    end
                end else if (accDone) begin
                    if (s_r.idx == aeb_pkg::LAST_WR_WORD) begin
                        s_nxt.memReq = 1'b0;
                        s_nxt.memWe  = 1'b0;
                        s_nxt.st     = aeb_pkg::ST_IDLE;
                        setDone      = 1'b1;
                    end else begin
                        s_nxt.idx      = s_r.idx + 4'h1;
                        s_nxt.memAddr  = s_r.memAddr + 32'h0000_0004;
                        s_nxt.memWdata = s_r.ciph[{s_nxt.idx[1:0], 5'h00} +: 32];
                    end
                end
            end
        endcase

        // software side of the registers
        if (wrPtr) begin
            s_nxt.ptr = regWdata;
        end
        if (wrIenSet) begin
            s_nxt.ien = s_r.ien | regWdata[1:0];
        end
        if (wrIenClr) begin
            s_nxt.ien = s_nxt.ien & ~regWdata[1:0];
        end
        if (wrDone) begin
            s_nxt.evtDone = regWdata[aeb_pkg::BIT_EVENT];
        end
        if (wrErr) begin
            s_nxt.evtErr = regWdata[aeb_pkg::BIT_EVENT];
        end
        // hardware set wins over a same-cycle clear
        if (setDone) begin
            s_nxt.evtDone = 1'b1;
        end
        if (setErr) begin
            s_nxt.evtErr = 1'b1;
        end
        if (s_nxt.st == aeb_pkg::ST_IDLE) begin
            s_nxt.abortPend = 1'b0;
        end

        // read data stands the cycle after the strobe
        s_nxt.rdata = 32'h0000_0000;
        if (regRd) begin
            unique case (regAddr)
                aeb_pkg::OFF_DONE:    s_nxt.rdata = {31'h0, s_r.evtDone};
                aeb_pkg::OFF_ERROR:   s_nxt.rdata = {31'h0, s_r.evtErr};
                aeb_pkg::OFF_IEN_SET: s_nxt.rdata = {30'h0, s_r.ien};
                aeb_pkg::OFF_IEN_CLR: s_nxt.rdata = {30'h0, s_r.ien};
                aeb_pkg::OFF_PTR:     s_nxt.rdata = s_r.ptr;
                default:              s_nxt.rdata = 32'h0000_0000;
            endcase
        end

        s_nxt.irq = (s_nxt.evtDone && s_nxt.ien[aeb_pkg::IEN_DONE])
                 || (s_nxt.evtErr && s_nxt.ien[aeb_pkg::IEN_ERROR]);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_r           <= '0;
            s_r.st        <= aeb_pkg::ST_IDLE;
            s_r.ptr       <= aeb_pkg::PTR_RST;
            s_r.ien       <= aeb_pkg::IEN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign regRdata  = s_r.rdata;
    assign memReq    = s_r.memReq;
    assign memWe     = s_r.memWe;
    assign memAddr   = s_r.memAddr;
    assign memWdata  = s_r.memWdata;
    assign coreStart = s_r.coreStart;
    assign coreKey   = s_r.key;
    assign coreText  = s_r.text;
    assign irq       = s_r.irq;

endmodule : aeb_block_encrypt

// ==== tb/aeb_block_encrypt_assertions.sv ====
`timescale 1ns/1ps
module aeb_block_encrypt_assertions (
    // clock and reset
    input wire logic         mclk,
    input wire logic         arst_n,
    // register port
    input wire logic [11:0]  regAddr,
    input wire logic [31:0]  regWdata,
    input wire logic         regWr,
    input wire logic         regRd,
    input wire logic [31:0]  regRdata,
    // dma and core
    input wire logic         memReq,
    input wire logic         memWe,
    input wire logic [31:0]  memAddr,
    input wire logic [31:0]  memWdata,
    input wire logic         memAck,
    input wire logic         coreBusy,
    input wire logic         coreClaim,
    input wire logic         coreStart,
    input wire logic [127:0] coreResult
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_win; memReq |-> memAddr >= 32'h2000_0000 && memAddr <= 32'h2000_7FFC; endproperty
    a_win: assert property (p_win) else $error("dma outside ram");
    property p_hold; memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe); endproperty
    a_hold: assert property (p_hold) else $error("dma request dropped");
    property p_fetch; coreStart |-> $past(memReq && memAck && !memWe) && !memReq; endproperty
    a_fetch: assert property (p_fetch) else $error("core start before fetch");
    property p_pulse; coreStart |=> !coreStart; endproperty
    a_pulse: assert property (p_pulse) else $error("core start too long");
    property p_wb; memReq && memWe |-> memWdata == coreResult[memAddr[3:2]*32 +: 32]; endproperty
    a_wb: assert property (p_wb) else $error("wrong ciphertext word");
    property p_busy;
        regWr && regAddr == 12'h000 && regWdata[0] && coreBusy && !memReq
            |=> (!memReq && !coreStart) [*2];
    endproperty
    a_busy: assert property (p_busy) else $error("start with busy core");
    property p_stop; regWr && regAddr == 12'h004 && regWdata[0] |=> !coreStart [*8]; endproperty
    a_stop: assert property (p_stop) else $error("stop not honoured");
    property p_claim; coreClaim && memReq |-> ##[1:10] !memReq; endproperty
    a_claim: assert property (p_claim) else $error("claim not honoured");
    property p_task; regRd && regAddr == 12'h004 |=> regRdata == 32'h0; endproperty
    a_task: assert property (p_task) else $error("task reads nonzero");
endmodule : aeb_block_encrypt_assertions

bind aeb_block_encrypt aeb_block_encrypt_assertions u_chk (.mclk(mclk), .arst_n(arst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .coreBusy(coreBusy), .coreClaim(coreClaim), .coreStart(coreStart), .coreResult(coreResult));

// ==== tb/aeb_ram_model.sv ====
`timescale 1ns/1ps
module aeb_ram_model (
    // clock, reset, pacing
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic [1:0]  latency,
    // dma slave
    input  wire logic        memReq,
    input  wire logic        memWe,
    input  wire logic [31:0] memAddr,
    input  wire logic [31:0] memWdata,
    output logic             memAck,
    output logic      [31:0] memRdata
);
    logic [31:0] mem [0:8191];
    logic [1:0]  waitCnt;
    logic [31:0] lastData;
    assign memAck = memReq && (waitCnt == latency);
    // released data line shows the inverse of the last value
    assign memRdata = (memAck && !memWe) ? mem[memAddr[14:2]] : ~lastData;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            waitCnt <= 2'h0;
            lastData <= 32'h0;
        end else begin
            waitCnt <= (memReq && !memAck) ? waitCnt + 2'h1 : 2'h0;
            if (memAck && memWe) mem[memAddr[14:2]] <= memWdata;
            if (memAck) lastData <= memWe ? memWdata : memRdata;
        end
    end
endmodule : aeb_ram_model

// ==== tb/test_aeb_block_encrypt.sv ====
`timescale 1ns/1ps
module test_aeb_block_encrypt;
    logic mclk, arst_n, regWr, regRd, memReq, memWe, memAck, coreBusy, coreClaim, coreStart, irq;
    logic [11:0]  regAddr;
    logic [31:0]  regWdata, regRdata, memAddr, memWdata, memRdata, evD, evE;
    logic [127:0] coreKey, coreText, coreResult;
    logic [1:0]   latency;
    logic [2:0]   doneSh = 3'h0;
    int           mismatches, comparisons, cycles;

    aeb_block_encrypt dut (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
        .memAck(memAck), .memRdata(memRdata), .coreBusy(coreBusy), .coreClaim(coreClaim),
        .coreStart(coreStart), .coreKey(coreKey), .coreText(coreText),
        .coreDone(doneSh[2]), .coreResult(coreResult), .irq(irq));
    aeb_ram_model ram (.mclk(mclk), .arst_n(arst_n), .latency(latency), .memReq(memReq),
        .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
        .memRdata(memRdata));

    // stand-in core: result three cycles after start
    assign coreResult = coreKey ^ coreText;
    always @(posedge mclk) doneSh <= {doneSh[1:0], coreStart};
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            summarize();
        end
    end

    function automatic logic [31:0] pat(input int i);
        return 32'h1234_5678 * (i + 1);
    endfunction : pat
    task automatic summarize();
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask : rc
    // key and cleartext preloaded, ciphertext slot zeroed; one call sets ptr so the structure runs past the ram end
    task automatic scen(input logic [31:0] p, input logic [1:0] lat, input logic busy,
                        input int stopAt, input int claimAt, input logic expD, input logic expI);
        for (int i = 0; i < 12; i++) begin
            ram.mem[(p[14:2] + i) % 8192] = (i < 8) ? pat(i) : 32'h0;
        end
        evD = 32'h0;
        evE = 32'h0;
        wr(12'h504, p);
        latency <= lat;
        coreBusy <= busy;
        wr(12'h000, 32'h1);
        if (stopAt > 0) begin
            repeat (stopAt) @(posedge mclk);
            wr(12'h004, 32'h1);
        end
        if (claimAt > 0) begin
            repeat (claimAt) @(posedge mclk);
            coreClaim <= 1'b1;
        end
        for (int n = 0; n < 40 && evD === 32'h0 && evE === 32'h0; n++) begin
            rd(12'h100, evD);
            rd(12'h104, evE);
        end
        @(posedge mclk);
        coreClaim <= 1'b0;
        coreBusy <= 1'b0;
        #1;
        chk(evD, {31'h0, expD});
        chk(evE, {31'h0, !expD});
        chk({31'h0, irq}, {31'h0, expI});
        for (int j = 0; j < 4; j++) begin
            chk(ram.mem[(p[14:2] + 8 + j) % 8192], expD ? pat(j) ^ pat(j + 4) : 32'h0);
        end
        wr(12'h100, 32'h0);
        wr(12'h104, 32'h0);
        @(posedge mclk);
        #1 chk({31'h0, irq}, 32'h0);
    endtask : scen

    initial begin
        {arst_n, regWr, regRd, coreBusy, coreClaim, regAddr, regWdata, latency} = '0;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        rc(12'h504, 32'h0);
        rc(12'h304, 32'h0);
        rc(12'h100, 32'h0);
        rc(12'h200, 32'h0);
        wr(12'h504, 32'hA5C3_1F0E);
        rc(12'h504, 32'hA5C3_1F0E);
        wr(12'h304, 32'h3);
        wr(12'h304, 32'h0);
        wr(12'h308, 32'h1);
        rc(12'h308, 32'h2);
        rc(12'h304, 32'h2);
        rc(12'h004, 32'h0);
        scen(32'h2000_0100, 2'h0, 1'b0, 0, 0, 1'b1, 1'b0);
        scen(32'h2000_7FD0, 2'h2, 1'b0, 0, 0, 1'b1, 1'b0);
        scen(32'h2000_7FE0, 2'h0, 1'b0, 0, 0, 1'b0, 1'b1);
        scen(32'h2000_0200, 2'h1, 1'b0, 3, 0, 1'b0, 1'b1);
        scen(32'h2000_0600, 2'h0, 1'b0, 10, 0, 1'b0, 1'b1);
        scen(32'h2000_0300, 2'h0, 1'b1, 0, 0, 1'b0, 1'b1);
        scen(32'h2000_0400, 2'h0, 1'b0, 0, 4, 1'b0, 1'b1);
        wr(12'h304, 32'h1);
        scen(32'h2000_0500, 2'h1, 1'b0, 0, 0, 1'b1, 1'b1);
        wr(12'h000, 32'h0);
        repeat (30) @(posedge mclk);
        rc(12'h100, 32'h0);
        rc(12'h104, 32'h0);
        summarize();
    end
endmodule : test_aeb_block_encrypt
